// ==== hw/vectored_interrupt_controller.sv ====
// vectored interrupt controller with register port, 32 requests, 16 slots
`timescale 1ns/1ns
module vectored_interrupt_controller (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic priv_i,
    input wire logic [31:0] req_i,
    output logic [31:0] rdata_o,
    output logic fast_req_o,
    output logic normal_req_o
);

    // ********************************
    // decode helpers
    // ********************************
    function automatic logic bank_hit(input logic [31:0] a, input logic [31:0] base);
        return a[31:vic_pkg::BANK_LSB] == base[31:vic_pkg::BANK_LSB];
    endfunction : bank_hit

    // returns {found, slot}; lowest slot wins, so duplicates resolve low
    function automatic logic [4:0] pick_winner(input logic [15:0] m);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (m[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : pick_winner

    // ********************************
    // state
    // ********************************
    logic [31:0] force_reg;
    logic [31:0] enable_reg;
    logic [31:0] class_reg;
    logic [31:0] def_addr_reg;
    logic prot_reg;
    logic [31:0] slot_addr_reg [vic_pkg::NUM_SLOTS];
    logic [5:0] slot_ctl_reg [vic_pkg::NUM_SLOTS];
    logic [16:0] in_service_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic fast_reg;
    logic normal_reg;

    logic access_ok;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] raw_status;
    logic [31:0] normal_status;
    logic [31:0] fast_status;
    logic [15:0] slot_match;
    logic [4:0] winner;
    logic [31:0] vect_addr;
    logic [16:0] service_bit;

    assign rdata_o = rdata_reg;
    assign fast_req_o = fast_reg;
    assign normal_req_o = normal_reg;

    // ********************************
    // access control
    // ********************************
    // with the protection bit set, user-mode accesses are dropped silently; reads then return zero
    assign access_ok = !prot_reg || priv_i;
    assign wr_ok = wr_i && access_ok;
    assign rd_ok = rd_i && access_ok;

    // ********************************
    // request path
    // ********************************
    // unconnected channels are cut here so only force can raise them
    assign raw_status = (req_i & vic_pkg::PERIPH_MASK) | force_reg;
    assign normal_status = raw_status & enable_reg & ~class_reg;
    assign fast_status = raw_status & enable_reg & class_reg;

    // ********************************
    // vector slots
    // ********************************
    // a disabled slot only drops the vector; the request stays in normal status
    generate
        for (genvar g = 0; g < 16; g++) begin : gen_slot
            assign slot_match[g] = slot_ctl_reg[g][vic_pkg::SLOT_EN_BIT]
                && normal_status[slot_ctl_reg[g][vic_pkg::SLOT_NUM_MSB:0]];

            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    slot_addr_reg[g] <= vic_pkg::RST_WORD;
                    slot_ctl_reg[g] <= vic_pkg::RST_SLOT_CTL;
                end else if (wr_ok && bank_hit(addr_i, vic_pkg::OFF_SLOT_ADDR)
                        && addr_i[5:2] == 4'(g)) begin
                    slot_addr_reg[g] <= wdata_i;
                end else if (wr_ok && bank_hit(addr_i, vic_pkg::OFF_SLOT_CTL)
                        && addr_i[5:2] == 4'(g)) begin
                    slot_ctl_reg[g] <= wdata_i[5:0];
                end
            end
        end
    endgenerate

    assign winner = pick_winner(slot_match);
    assign vect_addr = winner[4] ? slot_addr_reg[winner[3:0]] : def_addr_reg;
    assign service_bit = winner[4] ? (17'h0_0001 << winner[3:0]) : 17'h1_0000;

    // ********************************
    // software force
    // ********************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            force_reg <= vic_pkg::RST_WORD;
        end else if (wr_ok && addr_i == vic_pkg::OFF_FORCE) begin
            force_reg <= force_reg | wdata_i;
        end else if (wr_ok && addr_i == vic_pkg::OFF_FORCE_CLR) begin
            force_reg <= force_reg & ~wdata_i;
        end
    end

    // ********************************
    // enable and classification
    // ********************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_reg <= vic_pkg::RST_WORD;
        end else if (wr_ok && addr_i == vic_pkg::OFF_ENABLE) begin
            enable_reg <= enable_reg | wdata_i;
        end else if (wr_ok && addr_i == vic_pkg::OFF_ENABLE_CLR) begin
            enable_reg <= enable_reg & ~wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            class_reg <= vic_pkg::RST_WORD;
        end else if (wr_ok && addr_i == vic_pkg::OFF_CLASS) begin
            class_reg <= wdata_i;
        end
    end

    // ********************************
    // protection and default vector
    // ********************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prot_reg <= vic_pkg::RST_PROT;
        end else if (wr_ok && addr_i == vic_pkg::OFF_PROT) begin
            prot_reg <= wdata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            def_addr_reg <= vic_pkg::RST_WORD;
        end else if (wr_ok && addr_i == vic_pkg::OFF_DEF_VECT) begin
            def_addr_reg <= wdata_i;
        end
    end

    // ********************************
    // in-service tracking
    // ********************************
    // a vector read marks the winning level busy; a vector write retires
    // the highest-priority busy level; bit 16 stands for the default vector
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_service_reg <= vic_pkg::RST_IN_SERVICE;
        end else if (rd_ok && addr_i == vic_pkg::OFF_VECT) begin
            in_service_reg <= in_service_reg | service_bit;
        end else if (wr_ok && addr_i == vic_pkg::OFF_VECT) begin
            in_service_reg <= in_service_reg & (in_service_reg - 17'h0_0001);
        end
    end

    // ********************************
    // read port
    // ********************************
    // data stands for one cycle only; unmapped or refused reads give zero
    always_comb begin
        rdata_next = vic_pkg::RST_WORD;
        if (rd_ok) begin
            if (addr_i == vic_pkg::OFF_RAW) begin
                rdata_next = raw_status;
            end else if (addr_i == vic_pkg::OFF_FORCE) begin
                rdata_next = force_reg;
            end else if (addr_i == vic_pkg::OFF_NORMAL) begin
                rdata_next = normal_status;
            end else if (addr_i == vic_pkg::OFF_FAST) begin
                rdata_next = fast_status;
            end else if (addr_i == vic_pkg::OFF_CLASS) begin
                rdata_next = class_reg;
            end else if (addr_i == vic_pkg::OFF_ENABLE) begin
                rdata_next = enable_reg;
            end else if (addr_i == vic_pkg::OFF_PROT) begin
                rdata_next = {31'h0000_0000, prot_reg};
            end else if (addr_i == vic_pkg::OFF_VECT) begin
                rdata_next = vect_addr;
            end else if (addr_i == vic_pkg::OFF_DEF_VECT) begin
                rdata_next = def_addr_reg;
            end else if (addr_i == vic_pkg::OFF_IN_SERVICE) begin
                rdata_next = {15'h0000, in_service_reg};
            end else if (bank_hit(addr_i, vic_pkg::OFF_SLOT_ADDR)) begin
                rdata_next = slot_addr_reg[addr_i[5:2]];
            end else if (bank_hit(addr_i, vic_pkg::OFF_SLOT_CTL)) begin
                rdata_next = {26'h000_0000, slot_ctl_reg[addr_i[5:2]]};
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= vic_pkg::RST_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ********************************
    // core request outputs
    // ********************************
    // registered so the core sees clean levels, at one cycle of latency
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_reg <= 1'b0;
            normal_reg <= 1'b0;
        end else begin
            fast_reg <= |fast_status;
            normal_reg <= |normal_status;
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_write(logic [31:0] off);
        wr_i && access_ok && addr_i == off;
    endsequence

    sequence s_read(logic [31:0] off);
        rd_i && access_ok && addr_i == off;
    endsequence

    a_force_set: assert property (s_write(vic_pkg::OFF_FORCE)
        |=> ((force_reg & $past(wdata_i)) == $past(wdata_i))
        && ((force_reg & ~$past(wdata_i)) == ($past(force_reg) & ~$past(wdata_i))))
        else $error("force write did not set exactly the written ones");

    a_force_clear: assert property (s_write(vic_pkg::OFF_FORCE_CLR)
        |=> (force_reg & $past(wdata_i)) == 32'h0000_0000)
        else $error("force clear left a bit set");

    a_enable_clear: assert property (s_write(vic_pkg::OFF_ENABLE_CLR)
        |=> enable_reg == ($past(enable_reg) & ~$past(wdata_i)))
        else $error("enable clear gave the wrong enable value");

    a_raw_read: assert property (s_read(vic_pkg::OFF_RAW)
        |=> rdata_o == (($past(req_i) & vic_pkg::PERIPH_MASK) | $past(force_reg)))
        else $error("raw status read mismatch");

    a_chan_one_raw: assert property (raw_status[1] == force_reg[1])
        else $error("channel one raised without force");

    a_fast_out: assert property (##1
        fast_req_o == $past(|(raw_status & enable_reg & class_reg)))
        else $error("fast output does not follow fast status");

    a_normal_out: assert property (##1
        normal_req_o == $past(|(raw_status & enable_reg & ~class_reg)))
        else $error("normal output does not follow normal status");

    a_vect_default: assert property (s_read(vic_pkg::OFF_VECT)
        ##0 slot_match == 16'h0000
        |=> rdata_o == $past(def_addr_reg))
        else $error("default vector not returned");

    a_vect_slot0: assert property (s_read(vic_pkg::OFF_VECT) ##0 slot_match[0]
        |=> rdata_o == $past(slot_addr_reg[0]))
        else $error("slot zero did not win");

    a_prot_block: assert property (rd_i && prot_reg && !priv_i
        |=> rdata_o == 32'h0000_0000)
        else $error("user read passed protection");

    a_vect_write_keeps: assert property (s_write(vic_pkg::OFF_VECT)
        |=> def_addr_reg == $past(def_addr_reg)
        && in_service_reg == ($past(in_service_reg) & ($past(in_service_reg) - 17'h0_0001)))
        else $error("vector write changed stored state wrongly");

    // ********************************
    // further register checks
    // ********************************
    // read checks compare rdata_o; write checks and a_raw_periph compare the stored registers and status directly
    a_enable_set: assert property (s_write(vic_pkg::OFF_ENABLE)
        |=> enable_reg == ($past(enable_reg) | $past(wdata_i)))
        else $error("enable write did not set the written ones");

    a_enable_read: assert property (s_read(vic_pkg::OFF_ENABLE)
        |=> rdata_o == $past(enable_reg))
        else $error("enable read mismatch");

    a_force_read: assert property (s_read(vic_pkg::OFF_FORCE)
        |=> rdata_o == $past(force_reg))
        else $error("force read mismatch");

    a_fclear_read: assert property (s_read(vic_pkg::OFF_FORCE_CLR)
        |=> rdata_o == 32'h0000_0000)
        else $error("write-only force clear read back nonzero");

    a_class_write: assert property (s_write(vic_pkg::OFF_CLASS)
        |=> class_reg == $past(wdata_i))
        else $error("classification write mismatch");

    a_class_read: assert property (s_read(vic_pkg::OFF_CLASS)
        |=> rdata_o == $past(class_reg))
        else $error("classification read mismatch");

    a_normal_read: assert property (s_read(vic_pkg::OFF_NORMAL)
        |=> rdata_o == $past(raw_status & enable_reg & ~class_reg))
        else $error("normal status read mismatch");

    a_fast_read: assert property (s_read(vic_pkg::OFF_FAST)
        |=> rdata_o == $past(raw_status & enable_reg & class_reg))
        else $error("fast status read mismatch");

    a_raw_periph: assert property ((raw_status & ~force_reg & ~vic_pkg::PERIPH_MASK)
        == 32'h0000_0000)
        else $error("unused channel raised without force");

    a_out_masked: assert property (enable_reg == 32'h0000_0000
        |=> !fast_req_o && !normal_req_o)
        else $error("output raised with every request disabled");

    // ********************************
    // slot, vector and protection checks
    // ********************************
    a_slot_ctl_write: assert property (s_write(vic_pkg::OFF_SLOT_CTL)
        |=> slot_ctl_reg[0] == $past(wdata_i[5:0]))
        else $error("slot zero control write mismatch");

    a_slot_addr_write: assert property (s_write(vic_pkg::OFF_SLOT_ADDR)
        |=> slot_addr_reg[0] == $past(wdata_i))
        else $error("slot zero address write mismatch");

    a_slot_off: assert property (!slot_ctl_reg[15][vic_pkg::SLOT_EN_BIT]
        |-> !slot_match[15])
        else $error("disabled slot still matched");

    a_vect_lowest: assert property (s_read(vic_pkg::OFF_VECT)
        ##0 (slot_match[1:0] == 2'b10)
        |=> rdata_o == $past(slot_addr_reg[1]))
        else $error("slot one did not win over higher slots");

    a_service_mark: assert property (s_read(vic_pkg::OFF_VECT)
        |=> (in_service_reg & $past(service_bit)) == $past(service_bit))
        else $error("vector read did not mark the winner busy");

    a_prot_write: assert property (wr_i && prot_reg && !priv_i
        |=> def_addr_reg == $past(def_addr_reg) && prot_reg)
        else $error("user write passed protection");

endmodule : vectored_interrupt_controller

// ==== shared/vic_pkg.sv ====
// constants and register map of the vectored interrupt controller
// Behaviour
// - force bits ORed into requests first
// - force register: ones set, zeros ignored
// - force clear: ones clear force bits
// - raw status is request OR force
// - enable register: ones set, readable
// - enable clear: ones clear enable bits
// - classification one fast, zero normal
// - normal status: raw, enabled, not fast
// - fast status: raw, enabled, fast
// - fast output is OR of fast status
// - normal output is OR of normal status
// - sixteen slots, slot zero highest priority
// - slot control: enable bit5, number 4:0
// - disabled slot leaves request non-vectored
// - duplicate numbers: lower slot wins
// - vector read gives winner or default
// - vector write signals end of service
// - protection bit limits access to privileged
// - channel one driven by force only
// - peripheral channels zero to 21 used
package vic_pkg;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [31:0] OFF_RAW = 32'h0FFF_F008;
    localparam logic [31:0] OFF_FORCE = 32'h0FFF_F018;
    localparam logic [31:0] OFF_FORCE_CLR = 32'h0FFF_F01C;
    localparam logic [31:0] OFF_NORMAL = 32'hFFFF_F000;
    localparam logic [31:0] OFF_FAST = 32'hFFFF_F004;
    localparam logic [31:0] OFF_CLASS = 32'hFFFF_F00C;
    localparam logic [31:0] OFF_ENABLE = 32'hFFFF_F010;
    localparam logic [31:0] OFF_ENABLE_CLR = 32'hFFFF_F014;
    localparam logic [31:0] OFF_PROT = 32'hFFFF_F020;
    localparam logic [31:0] OFF_VECT = 32'hFFFF_F030;
    localparam logic [31:0] OFF_DEF_VECT = 32'hFFFF_F034;
    localparam logic [31:0] OFF_IN_SERVICE = 32'hFFFF_F040;
    localparam logic [31:0] OFF_SLOT_ADDR = 32'hFFFF_F100;
    localparam logic [31:0] OFF_SLOT_CTL = 32'hFFFF_F200;

    // ********************************
    // fields and sizes
    // ********************************
    localparam int unsigned NUM_SLOTS = 16;
    localparam int unsigned SLOT_EN_BIT = 5;
    localparam int unsigned SLOT_NUM_MSB = 4;
    localparam int unsigned BANK_LSB = 6;
    localparam int unsigned IN_SERVICE_W = 17;
    localparam logic [31:0] PERIPH_MASK = 32'h003F_FFFD;

    // ********************************
    // reset values
    // ********************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [5:0] RST_SLOT_CTL = 6'h00;
    localparam logic [16:0] RST_IN_SERVICE = 17'h0_0000;
    localparam logic RST_PROT = 1'b0;

endpackage : vic_pkg

// ==== dv/core_model.sv ====
// behavioural model of the processor core's interrupt inputs
`timescale 1ns/1ns
module core_model #(
    parameter int TAKE_DELAY = 3
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic fast_req_i,
    input wire logic normal_req_i,
    output logic fast_taken_o,
    output logic normal_taken_o
);
    // ********************************
    // request latching
    // ********************************
    // a request must stay up TAKE_DELAY cycles before the core commits to it,
    // so a short glitch is not taken; raise TAKE_DELAY for a slow core
    int fast_cnt_reg;
    int normal_cnt_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_cnt_reg <= 0;
            normal_cnt_reg <= 0;
        end else begin
            fast_cnt_reg <= fast_req_i ? fast_cnt_reg + 1 : 0;
            normal_cnt_reg <= normal_req_i ? normal_cnt_reg + 1 : 0;
        end
    end
    assign fast_taken_o = (fast_cnt_reg >= TAKE_DELAY);
    assign normal_taken_o = (normal_cnt_reg >= TAKE_DELAY);
endmodule : core_model

// ==== dv/tb_vectored_interrupt_controller.sv ====
// self-checking testbench of the vectored interrupt controller
`timescale 1ns/1ns
module tb_vectored_interrupt_controller;
    logic sys_clk_i, rst_n_i, wr_i, rd_i, priv_i, priv, fast_req_o, normal_req_o;
    logic fast_taken, normal_taken;
    logic [31:0] addr_i, wdata_i, req_i, rdata_o;
    int miscompares = 0;
    int n_compared = 0;
    int k;
    logic [31:0] map_a [0:12] = '{vic_pkg::OFF_RAW, vic_pkg::OFF_FORCE, vic_pkg::OFF_FORCE_CLR,
        vic_pkg::OFF_NORMAL, vic_pkg::OFF_FAST, vic_pkg::OFF_CLASS, vic_pkg::OFF_ENABLE,
        vic_pkg::OFF_ENABLE_CLR, vic_pkg::OFF_PROT, vic_pkg::OFF_VECT, vic_pkg::OFF_DEF_VECT,
        vic_pkg::OFF_SLOT_CTL + 32'h3C, 32'hFFFF_F300};

    vectored_interrupt_controller dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .priv_i(priv_i),
        .req_i(req_i), .rdata_o(rdata_o), .fast_req_o(fast_req_o), .normal_req_o(normal_req_o));
    core_model #(.TAKE_DELAY(3)) core_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .fast_req_i(fast_req_o), .normal_req_i(normal_req_o), .fast_taken_o(fast_taken),
        .normal_taken_o(normal_taken));

    // ********************************
    // shared tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("compares %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // whole-word accesses only: the port has no byte lanes
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        priv_i <= priv;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        priv_i <= priv;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask : reg_rd

    task automatic outs(input logic f, input logic n);
        repeat (2) @(posedge sys_clk_i);
        #1;
        check({31'h0, fast_req_o}, {31'h0, f});
        check({31'h0, normal_req_o}, {31'h0, n});
    endtask : outs

    // bounded wait: a core that never commits is counted and ends the run
    task automatic wait_taken;
        for (k = 0; k < 50 && normal_taken !== 1'b1; k++) @(posedge sys_clk_i);
        if (normal_taken !== 1'b1) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
            final_report();
        end
    endtask : wait_taken

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // ********************************
    // test sequence
    // ********************************
    initial begin
        {rst_n_i, wr_i, rd_i, priv_i} = 4'h0;
        priv = 1'b1;
        addr_i = 32'h0;
        wdata_i = 32'h0;
        req_i = 32'h0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        foreach (map_a[i]) reg_rd(map_a[i], 32'h0);
        outs(1'b0, 1'b0);
        $display("test reset done");
        reg_wr(vic_pkg::OFF_FORCE, 32'h8000_0012);
        reg_wr(vic_pkg::OFF_FORCE, 32'h0);
        reg_rd(vic_pkg::OFF_FORCE, 32'h8000_0012);
        reg_rd(vic_pkg::OFF_RAW, 32'h8000_0012);
        reg_wr(vic_pkg::OFF_FORCE_CLR, 32'h8000_0010);
        reg_rd(vic_pkg::OFF_FORCE, 32'h0000_0002);
        reg_rd(vic_pkg::OFF_FORCE_CLR, 32'h0);
        reg_wr(vic_pkg::OFF_FORCE_CLR, 32'hFFFF_FFFF);
        req_i <= 32'hFFFF_FFFF;
        reg_rd(vic_pkg::OFF_RAW, 32'h003F_FFFD);
        $display("test force done");
        req_i <= 32'h0000_0030;
        reg_wr(vic_pkg::OFF_ENABLE, 32'h0000_0070);
        reg_wr(vic_pkg::OFF_ENABLE, 32'h0);
        reg_wr(vic_pkg::OFF_ENABLE_CLR, 32'h0000_0040);
        reg_rd(vic_pkg::OFF_ENABLE, 32'h0000_0030);
        reg_wr(vic_pkg::OFF_CLASS, 32'h0000_0020);
        reg_rd(vic_pkg::OFF_CLASS, 32'h0000_0020);
        reg_rd(vic_pkg::OFF_NORMAL, 32'h0000_0010);
        reg_rd(vic_pkg::OFF_FAST, 32'h0000_0020);
        outs(1'b1, 1'b1);
        reg_wr(vic_pkg::OFF_CLASS, 32'h0);
        reg_rd(vic_pkg::OFF_NORMAL, 32'h0000_0030);
        outs(1'b0, 1'b1);
        $display("test classify done");
        reg_wr(vic_pkg::OFF_DEF_VECT, 32'hD000_0000);
        for (int n = 0; n < 16; n++) reg_wr(vic_pkg::OFF_SLOT_ADDR + 32'(4 * n), 32'hA000_0000 | n);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h0C, 32'h0000_0024);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h1C, 32'h0000_0025);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h08, 32'h0000_0005);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h24, 32'hFFFF_FFFF);
        reg_rd(vic_pkg::OFF_SLOT_CTL + 32'h24, 32'h0000_003F);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h24, 32'h0);
        wait_taken();
        reg_rd(vic_pkg::OFF_VECT, 32'hA000_0003);
        reg_wr(vic_pkg::OFF_VECT, 32'h0);
        reg_rd(vic_pkg::OFF_VECT, 32'hA000_0003);
        req_i <= 32'h0000_0020;
        reg_rd(vic_pkg::OFF_VECT, 32'hA000_0007);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h04, 32'h0000_0025);
        reg_rd(vic_pkg::OFF_VECT, 32'hA000_0001);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h04, 32'h0);
        reg_wr(vic_pkg::OFF_SLOT_CTL + 32'h1C, 32'h0000_0005);
        reg_rd(vic_pkg::OFF_VECT, 32'hD000_0000);
        outs(1'b0, 1'b1);
        req_i <= 32'h0;
        outs(1'b0, 1'b0);
        $display("test vectors done");
        reg_wr(vic_pkg::OFF_PROT, 32'h0000_0001);
        priv = 1'b0;
        reg_wr(vic_pkg::OFF_DEF_VECT, 32'h0000_1234);
        reg_rd(vic_pkg::OFF_DEF_VECT, 32'h0);
        priv = 1'b1;
        reg_rd(vic_pkg::OFF_DEF_VECT, 32'hD000_0000);
        reg_rd(vic_pkg::OFF_PROT, 32'h0000_0001);
        reg_wr(vic_pkg::OFF_PROT, 32'h0);
        priv = 1'b0;
        reg_rd(vic_pkg::OFF_DEF_VECT, 32'hD000_0000);
        reg_rd(vic_pkg::OFF_IN_SERVICE, 32'h0001_008A);
        $display("test protection done");
        final_report();
    end
endmodule : tb_vectored_interrupt_controller
